/* File: core/rsrc_ctrl.sv */
// Reset and stop-mode recovery controller with APB register slave
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "rsrc_map.svh"

// Overview of operation
// - Power-on or brown-out fault starts a system reset.
// - Watchdog time-out resets only when the watchdog action option says so.
// - Reset pin resets only while its reset alternate function is enabled.
// - Writing 1 to debugger control bit 0 in run mode starts a system reset.
// - In stop mode a watchdog time-out starts a stop-mode recovery.
// - In stop mode an enabled GPIO wake transition starts a recovery.
// - In stop mode a timer, comparator, LVD or RTC interrupt starts recovery.
// - Low-voltage detector raises an interrupt below the software threshold.
// - Every system reset resets control registers and CPU for 10 ms.
// - Recovery resets CPU and only cause and clock control regs.
// - Standard recovery releases CPU 6 cycles after the recovery delay.
// - Fast recovery releases CPU after 6 cycles with no recovery delay.
// - Reset pin pulses shorter than three clocks are ignored.
// - Reset pin still asserted after the delay keeps the device in reset.
// - Power-on or brown-out reset sets the supply-fault cause flag.
// - On release the CPU fetches its vector from addresses 0002h-0003h.
module rsrc_ctrl #(
  parameter int unsigned RESET_DELAY_CYC =
    `RSRC_RESET_DELAY_MS * (`RSRC_CLK_HZ / 1000),
  parameter int unsigned STOP_DELAY_CYC  = `RSRC_STOP_DELAY_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_fault,
  input  wire logic        lvd_below,
  input  wire logic        reset_pin_n,
  input  wire logic        pin_func_en,
  input  wire logic        wdt_timeout,
  input  wire logic        watchdog_action_option,
  input  wire logic        fast_recovery_option,
  input  wire logic        stop_enter,
  input  wire logic        gpio_wake,
  input  wire logic [2:0]  periph_wake,
  output logic             ctrl_rst_n_q,
  output logic             cpu_rst_n_q,
  output logic             recov_rst_n_q,
  output logic             osc_internal_q,
  output logic             stop_mode_q,
  output logic             vec_fetch_q,
  output logic      [15:0] reset_vector_q,
  output logic      [3:0]  lvd_threshold_q,
  output logic             irq_q
);
  rsrc_pkg::rsrc_state_e state_q, state_d;
  rsrc_pkg::rsrc_byte_t  cause_q, cause_d;
  rsrc_pkg::rsrc_byte_t  evt_q, evt_d, mask_q, ctrl_q, rdata;
  logic [31:0]           cnt_q, hold_cnt_q;
  logic [1:0]            async_in;
  logic [1:0]            s1_q, s2_q, s3_q, lvl_q;
  logic                  lvd_prev_q;
  logic                  pin_asserted;
  logic                  sup, lvd_rise, pin_rst, dbg_go, sys_src, wake;
  logic                  acc_wr, mapped, in_rec;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  rsrc_pin_filter u_pin (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_n      (reset_pin_n),
    .asserted_q (pin_asserted)
  );

  // Supply monitors are analog, so they pass the same three-stage sampler
  assign async_in = {lvd_below, supply_fault};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 2'h1;
      s2_q <= 2'h1;
      s3_q <= 2'h1;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_lvl
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lvl_q[i] <= (i == 0);
        end else if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

  assign sup      = lvl_q[0];
  assign lvd_rise = lvl_q[1] && !lvd_prev_q && ctrl_q[`RSRC_CTRL_LVD_EN];
  assign pin_rst  = pin_asserted && pin_func_en;
  assign acc_wr   = psel && penable && pready && pwrite;
  assign dbg_go   = acc_wr && hit(paddr, `RSRC_ADDR_DBG)
                    && pwdata[`RSRC_DBG_GO];
  assign sys_src  = (wdt_timeout && watchdog_action_option)
                    || pin_rst || dbg_go;
  assign wake     = wdt_timeout || gpio_wake
                    || (|periph_wake) || lvd_rise;
  assign in_rec   = (state_q == rsrc_pkg::ST_REC_DELAY)
                    || (state_q == rsrc_pkg::ST_REC_CPU);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rsrc_pkg::ST_SUPPLY: begin
        if (!sup) begin
          state_d = rsrc_pkg::ST_SYS_DELAY;
        end
      end
      rsrc_pkg::ST_SYS_DELAY: begin
        if (cnt_q == 32'(RESET_DELAY_CYC - 1)) begin
          state_d = pin_rst ? rsrc_pkg::ST_PIN_WAIT : rsrc_pkg::ST_RUN;
        end
      end
      rsrc_pkg::ST_PIN_WAIT: begin
        if (!pin_rst) begin
          state_d = rsrc_pkg::ST_RUN;
        end
      end
      rsrc_pkg::ST_RUN: begin
        if (sys_src) begin
          state_d = rsrc_pkg::ST_SYS_DELAY;
        end else if (stop_enter) begin
          state_d = rsrc_pkg::ST_STOP;
        end
      end
      rsrc_pkg::ST_STOP: begin
        if (pin_rst) begin
          state_d = rsrc_pkg::ST_SYS_DELAY;
        end else if (wake) begin
          state_d = fast_recovery_option ? rsrc_pkg::ST_REC_CPU
                                         : rsrc_pkg::ST_REC_DELAY;
        end
      end
      rsrc_pkg::ST_REC_DELAY: begin
        if (cnt_q == 32'(STOP_DELAY_CYC - 1)) begin
          state_d = rsrc_pkg::ST_REC_CPU;
        end
      end
      rsrc_pkg::ST_REC_CPU: begin
        if (cnt_q == 32'(`RSRC_CPU_REL_CYC - 1)) begin
          state_d = rsrc_pkg::ST_RUN;
        end
      end
      default: state_d = rsrc_pkg::ST_SUPPLY;
    endcase
    if (sup) begin
      state_d = rsrc_pkg::ST_SUPPLY;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= rsrc_pkg::ST_SUPPLY;
      cnt_q   <= 32'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? 32'h0 : cnt_q + 32'h1;
    end
  end

  // Cause is captured once, on entry to a reset or recovery
  always_comb begin
    cause_d = cause_q;
    if (state_d != state_q) begin
      if (state_d == rsrc_pkg::ST_SUPPLY) begin
        cause_d = 8'h00;
        cause_d[`RSRC_CAUSE_SUPPLY] = 1'b1;
      end else if (state_d == rsrc_pkg::ST_SYS_DELAY
                   && state_q != rsrc_pkg::ST_SUPPLY) begin
        cause_d = 8'h00;
        cause_d[`RSRC_CAUSE_WDT] = wdt_timeout && watchdog_action_option
                                   && state_q == rsrc_pkg::ST_RUN;
        cause_d[`RSRC_CAUSE_PIN] = pin_rst;
        cause_d[`RSRC_CAUSE_DBG] = dbg_go && state_q == rsrc_pkg::ST_RUN;
      end else if (state_q == rsrc_pkg::ST_STOP
                   && state_d != rsrc_pkg::ST_RUN) begin
        cause_d = 8'h00;
        cause_d[`RSRC_CAUSE_STOP] = 1'b1;
        cause_d[`RSRC_CAUSE_WDT]  = wdt_timeout;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= `RSRC_CAUSE_RST;
    end else begin
      cause_q <= cause_d;
    end
  end

  // One reset tree, all released on the clock edge that enters run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_rst_n_q   <= 1'b0;
      cpu_rst_n_q    <= 1'b0;
      recov_rst_n_q  <= 1'b0;
      osc_internal_q <= 1'b1;
      stop_mode_q    <= 1'b0;
      vec_fetch_q    <= 1'b0;
    end else begin
      ctrl_rst_n_q   <= !(state_d == rsrc_pkg::ST_SUPPLY
                          || state_d == rsrc_pkg::ST_SYS_DELAY
                          || state_d == rsrc_pkg::ST_PIN_WAIT);
      cpu_rst_n_q    <= state_d == rsrc_pkg::ST_RUN
                        || state_d == rsrc_pkg::ST_STOP;
      recov_rst_n_q  <= !(state_d == rsrc_pkg::ST_REC_DELAY
                          || state_d == rsrc_pkg::ST_REC_CPU);
      osc_internal_q <= !(state_d == rsrc_pkg::ST_RUN
                          || state_d == rsrc_pkg::ST_STOP);
      stop_mode_q    <= state_d == rsrc_pkg::ST_STOP;
      vec_fetch_q    <= state_d == rsrc_pkg::ST_RUN
                        && state_q != rsrc_pkg::ST_RUN
                        && state_q != rsrc_pkg::ST_STOP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_vector_q <= `RSRC_VEC_ADDR;
    end else begin
      reset_vector_q <= `RSRC_VEC_ADDR;
    end
  end

  // APB: no wait state, so every access completes on the second edge
  assign mapped = hit(paddr, `RSRC_ADDR_CAUSE) || hit(paddr, `RSRC_ADDR_EVT)
                  || hit(paddr, `RSRC_ADDR_MASK) || hit(paddr, `RSRC_ADDR_CTRL)
                  || hit(paddr, `RSRC_ADDR_DBG);

  always_comb begin
    rdata = 8'h00;
    if (hit(paddr, `RSRC_ADDR_CAUSE)) rdata = cause_q;
    if (hit(paddr, `RSRC_ADDR_EVT))   rdata = evt_q;
    if (hit(paddr, `RSRC_ADDR_MASK))  rdata = mask_q;
    if (hit(paddr, `RSRC_ADDR_CTRL))  rdata = ctrl_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable) begin
        prdata <= {24'h0, rdata};
      end
    end
  end

  // Threshold and mask survive recovery; a system reset restores them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `RSRC_CTRL_RST;
      mask_q <= `RSRC_MASK_RST;
    end else if (!ctrl_rst_n_q) begin
      ctrl_q <= `RSRC_CTRL_RST;
      mask_q <= `RSRC_MASK_RST;
    end else if (acc_wr) begin
      if (hit(paddr, `RSRC_ADDR_CTRL)) ctrl_q <= pwdata[7:0];
      if (hit(paddr, `RSRC_ADDR_MASK)) mask_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvd_threshold_q <= 4'h0;
    end else begin
      lvd_threshold_q <= ctrl_q[`RSRC_CTRL_THR_HI:0];
    end
  end

  // Write-one-to-clear; a new event in the same cycle wins
  always_comb begin
    evt_d = evt_q;
    if (acc_wr && hit(paddr, `RSRC_ADDR_EVT)) begin
      evt_d = evt_q & ~pwdata[7:0];
    end
    if (lvd_rise) evt_d[`RSRC_EVT_LVD] = 1'b1;
    if (state_q == rsrc_pkg::ST_REC_CPU && state_d == rsrc_pkg::ST_RUN) begin
      evt_d[`RSRC_EVT_RECOV] = 1'b1;
    end
    if (vec_fetch_q) evt_d[`RSRC_EVT_SYSRST] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q      <= `RSRC_EVT_RST;
      irq_q      <= 1'b0;
      lvd_prev_q <= 1'b0;
      hold_cnt_q <= 32'h0;
    end else begin
      evt_q      <= evt_d;
      irq_q      <= |(evt_d & mask_q);
      lvd_prev_q <= lvl_q[1];
      hold_cnt_q <= (state_q == rsrc_pkg::ST_SYS_DELAY)
                    ? hold_cnt_q + 32'h1 : 32'h0;
    end
  end

  sequence s_delay_done;
    state_q == rsrc_pkg::ST_REC_DELAY ##1 state_q == rsrc_pkg::ST_REC_CPU;
  endsequence
  sequence s_fast_start;
    state_q == rsrc_pkg::ST_STOP ##1 state_q == rsrc_pkg::ST_REC_CPU;
  endsequence
  sequence s_cpu_release;
    (!cpu_rst_n_q && !sup) [*6] ##1 cpu_rst_n_q;
  endsequence

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_supply_fault_rst: assert property (
    sup |=> state_q == rsrc_pkg::ST_SUPPLY && !cpu_rst_n_q && !ctrl_rst_n_q)
    else $error("supply fault did not reset");
  a_wdt_option_gate: assert property (
    state_q == rsrc_pkg::ST_RUN && !sup && wdt_timeout && !pin_rst
    && !dbg_go && !stop_enter |=> watchdog_action_option != cpu_rst_n_q)
    else $error("watchdog reset ignored its option");
  a_pin_func_gate: assert property (
    state_q == rsrc_pkg::ST_RUN && !sup && pin_asserted |=>
      cpu_rst_n_q == !pin_func_en || $past(sys_src) || $past(stop_enter))
    else $error("reset pin ignored its function enable");
  a_dbg_write_rst: assert property (
    state_q == rsrc_pkg::ST_RUN && !sup && dbg_go |=>
      !ctrl_rst_n_q && cause_q[`RSRC_CAUSE_DBG])
    else $error("debugger write did not reset");
  a_stop_wdt_wake: assert property (
    state_q == rsrc_pkg::ST_STOP && !sup && !pin_rst && wdt_timeout |=>
      in_rec && cause_q[`RSRC_CAUSE_STOP] && cause_q[`RSRC_CAUSE_WDT])
    else $error("watchdog did not start recovery");
  a_stop_gpio_wake: assert property (
    state_q == rsrc_pkg::ST_STOP && !sup && !pin_rst && gpio_wake |=>
      in_rec && !cpu_rst_n_q)
    else $error("gpio wake did not start recovery");
  a_stop_periph_wake: assert property (
    state_q == rsrc_pkg::ST_STOP && !sup && !pin_rst && |periph_wake |=>
      in_rec && !recov_rst_n_q)
    else $error("peripheral wake did not start recovery");
  a_lvd_irq_set: assert property (
    lvd_rise |=> evt_q[`RSRC_EVT_LVD]
      && (irq_q || !$past(mask_q[`RSRC_EVT_LVD])))
    else $error("low voltage event lost");
  a_sys_delay_len: assert property (
    $rose(ctrl_rst_n_q) && $past(state_q) == rsrc_pkg::ST_SYS_DELAY |->
      hold_cnt_q == 32'(RESET_DELAY_CYC))
    else $error("system reset delay has wrong length");
  a_recov_scope: assert property (
    in_rec |-> ctrl_rst_n_q && !recov_rst_n_q && !cpu_rst_n_q)
    else $error("recovery touched wrong reset group");
  a_std_recov_rel: assert property (
    s_delay_done |-> s_cpu_release or ##[0:6] sup)
    else $error("standard recovery release timing wrong");
  a_fast_recov_rel: assert property (
    s_fast_start |-> s_cpu_release or ##[0:6] sup)
    else $error("fast recovery release timing wrong");
  a_pin_hold_rst: assert property (
    state_q == rsrc_pkg::ST_PIN_WAIT && pin_rst |=> !cpu_rst_n_q)
    else $error("released while reset pin held");
  a_supply_cause: assert property (
    state_q == rsrc_pkg::ST_SUPPLY |-> cause_q[`RSRC_CAUSE_SUPPLY])
    else $error("supply fault flag not set");
  a_vector_fetch: assert property (
    $rose(ctrl_rst_n_q) |-> vec_fetch_q && cpu_rst_n_q
      && reset_vector_q == `RSRC_VEC_ADDR)
    else $error("reset release without vector fetch");
  a_single_tree: assert property (
    !ctrl_rst_n_q |-> !cpu_rst_n_q && osc_internal_q)
    else $error("cpu released during system reset");
endmodule

/* File: core/rsrc_pin_filter.sv */
// Reset pin synchroniser and short-pulse filter
`timescale 1ns/10ps
`include "rsrc_map.svh"

module rsrc_pin_filter (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_n,
  output logic      asserted_q
);
  logic [2:0] sync_q;
  logic [1:0] run_q;
  logic       agree;
  logic       differ;

  // Stage one only feeds stage two; agreement is judged on stages two, three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'h7;
    end else begin
      sync_q <= {sync_q[1:0], pin_n};
    end
  end

  assign agree  = (sync_q[1] == sync_q[2]);
  assign differ = agree && ((~sync_q[2]) != asserted_q);

  // Level must hold for the minimum width before the filtered state flips
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q      <= 2'h0;
      asserted_q <= 1'b0;
    end else if (!differ) begin
      run_q <= 2'h0;
    // The first agreeing sample already spans two pin samples, so a level
    // is taken once it has been seen on the minimum number of edges
    end else if (run_q == 2'(`RSRC_PIN_MIN_CYC - 2)) begin
      run_q      <= 2'h0;
      asserted_q <= ~asserted_q;
    end else begin
      run_q <= run_q + 2'h1;
    end
  end

  a_pin_short_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(asserted_q) |->
      $past(!sync_q[2], 1) && $past(!sync_q[2], 2) && $past(!sync_q[1], 1))
    else $error("reset pin accepted a pulse shorter than minimum");
endmodule

/* File: include/rsrc_map.svh */
// Register map, field positions and timing constants of the reset controller
`ifndef RSRC_MAP_SVH
`define RSRC_MAP_SVH

`define RSRC_ADDR_W         12
`define RSRC_ADDR_CAUSE     12'hFF0
`define RSRC_ADDR_EVT       12'hFF4
`define RSRC_ADDR_MASK      12'hFF8
`define RSRC_ADDR_CTRL      12'hFFC
`define RSRC_ADDR_DBG       12'hF00

`define RSRC_CAUSE_SUPPLY   7
`define RSRC_CAUSE_WDT      6
`define RSRC_CAUSE_PIN      5
`define RSRC_CAUSE_DBG      4
`define RSRC_CAUSE_STOP     3
`define RSRC_CAUSE_RST      8'h80

`define RSRC_EVT_LVD        0
`define RSRC_EVT_RECOV      1
`define RSRC_EVT_SYSRST     2
`define RSRC_EVT_RST        8'h00
`define RSRC_MASK_RST       8'h00

`define RSRC_CTRL_THR_HI    3
`define RSRC_CTRL_LVD_EN    4
`define RSRC_CTRL_RST       8'h00
`define RSRC_DBG_GO         0

`define RSRC_CLK_HZ         20000000
`define RSRC_RESET_DELAY_MS 10
`define RSRC_CPU_REL_CYC    6
`define RSRC_PIN_MIN_CYC    3
`define RSRC_STOP_DELAY_CYC 20
`define RSRC_VEC_ADDR       16'h0002

`endif

/* File: include/rsrc_pkg.sv */
// Types shared by the reset controller files
package rsrc_pkg;
  typedef enum logic [2:0] {
    ST_SUPPLY,
    ST_SYS_DELAY,
    ST_PIN_WAIT,
    ST_RUN,
    ST_STOP,
    ST_REC_DELAY,
    ST_REC_CPU
  } rsrc_state_e;

  typedef logic [7:0] rsrc_byte_t;
endpackage

/* File: verif/rsrc_ctrl_test.sv */
// Self-checking bench for the reset and stop-mode recovery controller
`timescale 1ns/10ps
`include "rsrc_map.svh"
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
    end \
  end

module rsrc_ctrl_test;
  localparam int unsigned DLY  = 20;
  localparam int unsigned SDLY = 20;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, supply_fault, lvd_below, reset_pin_n;
  logic        pin_func_en = 1'b0;
  logic        watchdog_action_option = 1'b0;
  logic        fast_recovery_option = 1'b0;
  logic        wdt_timeout, stop_enter, gpio_wake;
  logic [2:0]  periph_wake;
  logic        ctrl_rst_n_q, cpu_rst_n_q, recov_rst_n_q, osc_internal_q;
  logic        stop_mode_q, vec_fetch_q, irq_q, er, fast;
  logic [15:0] reset_vector_q;
  logic [3:0]  lvd_threshold_q, thr;
  logic [7:0]  rd;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          seed, r0, c0;

  rsrc_ctrl #(.RESET_DELAY_CYC(DLY), .STOP_DELAY_CYC(SDLY)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_fault(supply_fault),
    .lvd_below(lvd_below), .reset_pin_n(reset_pin_n),
    .pin_func_en(pin_func_en), .wdt_timeout(wdt_timeout),
    .watchdog_action_option(watchdog_action_option),
    .fast_recovery_option(fast_recovery_option), .stop_enter(stop_enter),
    .gpio_wake(gpio_wake), .periph_wake(periph_wake),
    .ctrl_rst_n_q(ctrl_rst_n_q), .cpu_rst_n_q(cpu_rst_n_q),
    .recov_rst_n_q(recov_rst_n_q), .osc_internal_q(osc_internal_q),
    .stop_mode_q(stop_mode_q), .vec_fetch_q(vec_fetch_q),
    .reset_vector_q(reset_vector_q), .lvd_threshold_q(lvd_threshold_q),
    .irq_q(irq_q));

  rsrc_far_model far_u (
    .pclk(pclk), .cpu_rst_n_q(cpu_rst_n_q), .ctrl_rst_n_q(ctrl_rst_n_q),
    .vec_fetch_q(vec_fetch_q), .reset_vector_q(reset_vector_q),
    .supply_fault(supply_fault), .lvd_below(lvd_below),
    .reset_pin_n(reset_pin_n), .wdt_timeout(wdt_timeout),
    .gpio_wake(gpio_wake), .periph_wake(periph_wake),
    .stop_enter(stop_enter));

  initial begin
    forever #25 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("Checks made %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Entered just after an edge; leaves one idle edge so strobes never clash
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) error_cnt++;
    @(posedge pclk);
  endtask

  task automatic wait_rel(input int r);
    int n;
    n = 0;
    while (far_u.releases == r && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      error_cnt++;
      $display("CHECK FAILED release exp done got timeout");
    end
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("CHECK FAILED run exp finished got hang");
    give_verdict;
  end

  initial begin
    seed = 32'h92F4;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_rel(0);
    apb(1'b0, `RSRC_ADDR_CAUSE, 8'h00);
    `CHK("cause por", 8'h80, rd)
    `CHK("vector", `RSRC_VEC_ADDR, far_u.fetch_addr)
    apb(1'b1, `RSRC_ADDR_CAUSE, 8'h00);
    apb(1'b0, `RSRC_ADDR_CAUSE, 8'h00);
    `CHK("cause ro", 8'h80, rd)
    apb(1'b0, 12'h100, 8'h00);
    `CHK("unmapped", 1'b1, er)
    // Debugger reset must also wipe the control register
    apb(1'b1, `RSRC_ADDR_CTRL, 8'h15);
    apb(1'b1, `RSRC_ADDR_EVT, 8'hFF);
    r0 = far_u.releases;
    c0 = far_u.ctrl_lows;
    apb(1'b1, `RSRC_ADDR_DBG, 8'h01);
    wait_rel(r0);
    `CHK("dbg span", 1'b1, far_u.span >= DLY && far_u.span <= DLY + 2)
    `CHK("ctrl held", 1'b1, far_u.ctrl_lows - c0 >= DLY)
    apb(1'b0, `RSRC_ADDR_CAUSE, 8'h00);
    `CHK("cause dbg", 8'h10, rd)
    apb(1'b0, `RSRC_ADDR_CTRL, 8'h00);
    `CHK("ctrl cleared", 8'h00, rd)
    apb(1'b0, `RSRC_ADDR_EVT, 8'h00);
    `CHK("sysrst event", 1'b1, rd[`RSRC_EVT_SYSRST])
    apb(1'b1, `RSRC_ADDR_EVT, 8'hFF);
    apb(1'b0, `RSRC_ADDR_EVT, 8'h00);
    `CHK("event w1c", 8'h00, rd)
    for (int opt = 0; opt < 2; opt++) begin
      watchdog_action_option <= opt[0];
      @(posedge pclk);
      r0 = far_u.releases;
      far_u.pulse(0);
      repeat (12) @(posedge pclk);
      `CHK("wdt cpu", ~opt[0], cpu_rst_n_q)
    end
    wait_rel(r0);
    apb(1'b0, `RSRC_ADDR_CAUSE, 8'h00);
    `CHK("cause wdt", 8'h40, rd)
    watchdog_action_option <= 1'b0;
    far_u.hold_pin(10);
    repeat (8) @(posedge pclk);
    `CHK("pin disabled", 1'b1, cpu_rst_n_q)
    pin_func_en <= 1'b1;
    @(posedge pclk);
    far_u.hold_pin(1 + ($random(seed) & 1));
    repeat (10) @(posedge pclk);
    `CHK("pin glitch", 1'b1, cpu_rst_n_q)
    r0 = far_u.releases;
    far_u.hold_pin(DLY * 3);
    wait_rel(r0);
    `CHK("pin held", 1'b1, far_u.span > DLY + 10)
    apb(1'b0, `RSRC_ADDR_CAUSE, 8'h00);
    `CHK("cause pin", 8'h20, rd)
    // Wake sources: watchdog, gpio, three peripherals, then low voltage
    for (int k = 0; k < 6; k++) begin
      fast = 1'($random(seed));
      fast_recovery_option <= fast;
      if (k == 5) begin
        thr = 4'($random(seed));
        apb(1'b1, `RSRC_ADDR_CTRL, {4'h1, thr});
        apb(1'b1, `RSRC_ADDR_MASK, 8'h01);
      end
      far_u.pulse(5);
      repeat (3) @(posedge pclk);
      `CHK("stop", 1'b1, stop_mode_q)
      r0 = far_u.releases;
      c0 = far_u.ctrl_lows;
      if (k < 5) begin
        far_u.pulse(k);
        @(posedge pclk);
        `CHK("recov rst", 1'b0, recov_rst_n_q)
        `CHK("internal osc", 1'b1, osc_internal_q)
      end else begin
        far_u.set_level(1'b0, 1'b1);
      end
      wait_rel(r0);
      `CHK("recov span", fast ? 6 : SDLY + 6, far_u.span)
      `CHK("regs kept", c0, far_u.ctrl_lows)
      apb(1'b0, `RSRC_ADDR_CAUSE, 8'h00);
      `CHK("cause stop", (k == 0) ? 8'h48 : 8'h08, rd)
    end
    `CHK("threshold", thr, lvd_threshold_q)
    `CHK("lvd irq", 1'b1, irq_q)
    apb(1'b1, `RSRC_ADDR_MASK, 8'h00);
    // The interrupt follows the mask one edge after the write lands
    @(posedge pclk);
    `CHK("irq masked", 1'b0, irq_q)
    apb(1'b1, `RSRC_ADDR_MASK, 8'h01);
    apb(1'b1, `RSRC_ADDR_EVT, 8'h01);
    `CHK("irq cleared", 1'b0, irq_q)
    r0 = far_u.releases;
    far_u.set_level(1'b1, 1'b0);
    repeat (5) @(posedge pclk);
    far_u.set_level(1'b0, 1'b0);
    wait_rel(r0);
    `CHK("supply span", 1'b1, far_u.span >= DLY)
    apb(1'b0, `RSRC_ADDR_CAUSE, 8'h00);
    `CHK("cause supply", 8'h80, rd)
    give_verdict;
  end
endmodule

/* File: verif/rsrc_far_model.sv */
// Far side of the reset controller: supply monitors, wake sources, CPU
`timescale 1ns/10ps

module rsrc_far_model (
  input  wire logic        pclk,
  input  wire logic        cpu_rst_n_q,
  input  wire logic        ctrl_rst_n_q,
  input  wire logic        vec_fetch_q,
  input  wire logic [15:0] reset_vector_q,
  output logic             supply_fault,
  output logic             lvd_below,
  output logic             reset_pin_n,
  output logic             wdt_timeout,
  output logic             gpio_wake,
  output logic      [2:0]  periph_wake,
  output logic             stop_enter
);
  int          low_cnt    = 0;
  int          span       = 0;
  int          releases   = 0;
  int          ctrl_lows  = 0;
  logic [15:0] fetch_addr = 16'h0000;

  // Pin has a pull-up, so idle is high
  initial begin
    supply_fault = 1'b0;
    lvd_below    = 1'b0;
    reset_pin_n  = 1'b1;
    {stop_enter, periph_wake, gpio_wake, wdt_timeout} = 6'h00;
  end

  // CPU side: how long it sat in reset and where it fetched from
  always @(posedge pclk) begin
    if (ctrl_rst_n_q === 1'b0) ctrl_lows <= ctrl_lows + 1;
    if (cpu_rst_n_q === 1'b0) begin
      low_cnt <= low_cnt + 1;
    end else if (low_cnt != 0) begin
      span     <= low_cnt;
      releases <= releases + 1;
      low_cnt  <= 0;
    end
    if (vec_fetch_q === 1'b1) fetch_addr <= reset_vector_q;
  end

  // One-cycle event: 0 watchdog, 1 gpio, 2..4 peripherals, 5 stop entry
  task automatic pulse(input int k);
    {stop_enter, periph_wake, gpio_wake, wdt_timeout} <= 6'h01 << k;
    @(posedge pclk);
    {stop_enter, periph_wake, gpio_wake, wdt_timeout} <= 6'h00;
  endtask

  task automatic hold_pin(input int n);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask

  task automatic set_level(input logic sup, input logic lvd);
    supply_fault <= sup;
    lvd_below    <= lvd;
  endtask
endmodule
